// file: verilog/usc_pkg.sv
/*
 Constants, register map and types of the serial port status and
 control block. Assumes a 10 MHz clock and a 32-bit APB register bus.
*/
package usc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_STA = 8'h00;
    localparam logic [7:0] OFS_TXD = 8'h04;
    localparam logic [7:0] OFS_RXD = 8'h08;
    localparam logic [7:0] OFS_MODE = 8'h0c;
    // Status and control field positions
    localparam int B_ADM = 24;
    localparam int B_ADDR = 16;
    localparam int B_TXSEL = 14;
    localparam int B_POL = 13;
    localparam int B_RXEN = 12;
    localparam int B_BRK = 11;
    localparam int B_TXEN = 10;
    localparam int B_RXSEL = 6;
    localparam int B_ADDRESS_CHAR_DETECT = 5;
    localparam int B_OVERRUN_ERROR_FLAG = 1;
    // Mode register field positions
    localparam int B_ON = 15;
    localparam int B_IR = 12;
    // Transmit interrupt select codes
    localparam logic [1:0] TXI_ROOM = 2'h0;
    localparam logic [1:0] TXI_DONE = 2'h1;
    localparam logic [1:0] TXI_EMPTY = 2'h2;
    // Timing: clock rate and oversampling
    localparam int CLK_HZ = 10_000_000;
    localparam int OVS = 16;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] HALF_LAST = 4'h7;
    localparam logic [3:0] IR_PULSE = 4'h3;
    localparam logic [2:0] DATA_LAST = 3'h7;
    // Frame lengths in bit times, stop bit included
    localparam logic [3:0] FRM_BITS = 4'ha;
    localparam logic [3:0] BRK_BITS = 4'he;
    localparam logic [13:0] BRK_FRAME = 14'h2000;
    // Software controls carried as one bundle
    typedef struct packed {
        logic adm;
        logic [7:0] addr;
        logic [1:0] txsel;
        logic pol;
        logic rxen;
        logic brk;
        logic txen;
        logic [1:0] rxsel;
        logic address_char_detect;
        logic on;
        logic ir;
    } usc_ctrl_t;
    typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} usc_tx_st_t;
    typedef enum logic [1:0] {
        R_IDLE = 2'b00,
        R_START = 2'b01,
        R_DATA = 2'b10,
        R_STOP = 2'b11
    } usc_rx_st_t;
endpackage

// file: verilog/usc_core.sv
/*
 Transmit FIFO and the serial port status/control top module.
 Assumes an APB master on clk_i and an asynchronous serial peer on
 the pins; the receive pin is synchronised here.
*/
`timescale 1ns/100ps

// Transmit character FIFO, flushable
module usc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic out_ready_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic full_o,
    output logic empty_o
);
    localparam int AW = $clog2(DEPTH);
    // Pointers wrap naturally only at a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("usc_fifo DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH]; // Storage
    logic [AW-1:0] wp, rp, next_wp, next_rp; // Pointers
    logic [AW:0] cnt, next_cnt; // Fill level
    logic push, pop;
    assign full_o = (cnt == (AW+1)'(DEPTH));
    assign empty_o = (cnt == '0);
    assign in_ready_o = !full_o;
    assign out_valid_o = !empty_o;
    assign out_data_o = mem[rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    // Next pointers; flush drops everything held
    always_comb begin
        next_wp = wp + AW'(push);
        next_rp = rp + AW'(pop);
        next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i) begin
            next_wp = '0;
            next_rp = '0;
            next_cnt = '0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end
    // Data array needs no reset
    always_ff @(posedge clk_i) begin
        if (push && !flush_i) begin
            mem[wp] <= in_data_i;
        end
    end
endmodule

// Notes on behaviour
// - Address detect active only while enable set
// - Compare received characters against address field
// - Select 10: interrupt while buffer empty
// - Select 01: interrupt once everything sent
// - Select 00: interrupt while buffer has room
// - Plain mode: polarity one idles low
// - Infrared mode: polarity one idles high
// - Receiver enable and on own the pin
// - Break: start, twelve zeros, stop; self-clears
// - Transmit disable aborts, flushes, releases pin
// - Buffer full flag mirrors FIFO full
// - Upper status bits read zero
module usc_top import usc_pkg::*; #(
    parameter int BAUD = 9600,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_o,
    output logic rx_pin_owned_o,
    output logic tx_irq_o
);
    localparam int DIV = CLK_HZ / (BAUD * OVS); // Clocks per tick
    localparam logic [15:0] DIV_LAST = 16'(DIV - 1);
    if (DIV < 1 || DIV > 65536) begin : g_chk
        $error("usc_top BAUD out of range for the clock");
    end

    usc_ctrl_t ctrl, next_ctrl; // Software controls
    logic ovr, next_ovr; // Overrun flag
    logic rx_valid, next_rx_valid; // Receive data available
    logic [7:0] rx_data, next_rx_data; // Receive holding word
    logic framing_error_flag, next_framing_error_flag; // Framing error of held word
    logic matched, next_matched; // Address seen
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_tx_irq, next_rx_own;
    logic acc, done, wr_sta, wr_txd, rd_rxd, hit;
    logic tx_on, rx_own, tx_pop, brk_done;
    logic f_full, f_empty, f_valid, f_in_ready;
    logic [7:0] f_data;
    logic [15:0] div, next_div; // Tick divider
    logic tick, next_tick; // One-cycle oversample enable

    // APB phase decode; effects happen on the completing edge
    assign acc = psel_i && penable_i;
    assign done = acc && pready_o;
    assign wr_sta = done && pwrite_i && paddr_i == OFS_STA;
    assign wr_txd = done && pwrite_i && paddr_i == OFS_TXD;
    assign rd_rxd = done && !pwrite_i && paddr_i == OFS_RXD;
    assign hit = paddr_i == OFS_STA || paddr_i == OFS_TXD
        || paddr_i == OFS_RXD || paddr_i == OFS_MODE;
    assign tx_on = ctrl.txen && ctrl.on;
    assign rx_own = ctrl.rxen && ctrl.on;

    usc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .flush_i(!tx_on),
        .in_valid_i(wr_txd),
        .in_data_i(pwdata_i[7:0]),
        .out_ready_i(tx_pop),
        .in_ready_o(f_in_ready),
        .out_valid_o(f_valid),
        .out_data_o(f_data),
        .full_o(f_full),
        .empty_o(f_empty)
    );

    usc_tx_st_t tx_st, next_tx_st;
    logic [13:0] tx_sh, next_tx_sh; // Frame, LSB goes out first
    logic [3:0] tx_cnt, next_tx_cnt; // Bit times left
    logic [3:0] tx_sub, next_tx_sub; // Ticks into the bit
    logic tx_brk, next_tx_brk; // Frame is a break
    logic next_pin, next_oe;
    usc_rx_st_t rx_st, next_rx_st;
    logic rx_s1, rx_s2, rx_line; // Pin synchroniser
    logic [3:0] rx_sub, next_rx_sub;
    logic [2:0] rx_cnt, next_rx_cnt;
    logic [7:0] rx_sh, next_rx_sh;
    logic rx_done, rx_bad, rx_take;

    // Status word; flags packed from hardware state
    function automatic logic [31:0] sta_word(input usc_ctrl_t c,
        input logic full, input logic tx_shift_empty, input logic receiver_idle,
        input logic fe, input logic oe, input logic da);
        sta_word = {7'h00, c.adm, c.addr, c.txsel, c.pol, c.rxen,
            c.brk, c.txen, full, tx_shift_empty, c.rxsel, c.address_char_detect, receiver_idle,
            1'b0, fe, oe, da};
    endfunction

    // Register file, APB answer, interrupt and pin ownership
    always_comb begin
        next_ctrl = ctrl;
        next_ovr = ovr;
        next_rx_valid = rx_valid;
        next_rx_data = rx_data;
        next_framing_error_flag = framing_error_flag;
        next_matched = matched;
        next_prdata = prdata_o;
        next_pslverr = pslverr_o;
        // Answer one cycle into access; a full FIFO stalls a push
        next_pready = acc && !pready_o
            && !(pwrite_i && paddr_i == OFS_TXD && !f_in_ready);
        if (next_pready) begin
            next_pslverr = !hit;
            unique case (paddr_i)
                OFS_STA: next_prdata = sta_word(ctrl, f_full,
                    tx_st == TX_IDLE, rx_st == R_IDLE, framing_error_flag, ovr,
                    rx_valid);
                OFS_RXD: next_prdata = {24'h000000, rx_data};
                OFS_MODE: begin
                    next_prdata = 32'h00000000;
                    next_prdata[B_ON] = ctrl.on;
                    next_prdata[B_IR] = ctrl.ir;
                end
                default: next_prdata = 32'h00000000; // Also TXD
            endcase
        end
        // Hardware clears break at frame end
        if (brk_done) begin
            next_ctrl.brk = 1'b0;
        end
        if (wr_sta) begin
            next_ctrl.adm = pwdata_i[B_ADM];
            next_ctrl.addr = pwdata_i[B_ADDR +: 8];
            next_ctrl.txsel = pwdata_i[B_TXSEL +: 2];
            next_ctrl.pol = pwdata_i[B_POL];
            next_ctrl.rxen = pwdata_i[B_RXEN];
            // Software set wins over the hardware clear
            next_ctrl.brk = pwdata_i[B_BRK] || next_ctrl.brk;
            next_ctrl.txen = pwdata_i[B_TXEN];
            next_ctrl.rxsel = pwdata_i[B_RXSEL +: 2];
            next_ctrl.address_char_detect = pwdata_i[B_ADDRESS_CHAR_DETECT];
            if (!pwdata_i[B_OVERRUN_ERROR_FLAG]) begin
                next_ovr = 1'b0;
            end
        end
        if (done && pwrite_i && paddr_i == OFS_MODE) begin
            next_ctrl.on = pwdata_i[B_ON];
            next_ctrl.ir = pwdata_i[B_IR];
        end
        if (rd_rxd) begin
            next_rx_valid = 1'b0;
        end
        // Address filter: drop until the address character arrives
        if (!ctrl.adm) begin
            next_matched = 1'b0;
        end else if (rx_take) begin
            next_matched = 1'b1;
        end
        if (rx_take) begin
            if (next_rx_valid) begin
                next_ovr = 1'b1;
            end else begin
                next_rx_valid = 1'b1;
                next_rx_data = rx_sh;
                next_framing_error_flag = rx_bad;
            end
        end
        unique case (ctrl.txsel)
            TXI_ROOM: next_tx_irq = !f_full;
            TXI_DONE: next_tx_irq = f_empty && tx_st == TX_IDLE;
            TXI_EMPTY: next_tx_irq = f_empty;
            default: next_tx_irq = 1'b0; // Reserved code
        endcase
        next_rx_own = rx_own;
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl <= '0;
            ovr <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            framing_error_flag <= 1'b0;
            matched <= 1'b0;
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            tx_irq_o <= 1'b0;
            rx_pin_owned_o <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            ovr <= next_ovr;
            rx_valid <= next_rx_valid;
            rx_data <= next_rx_data;
            framing_error_flag <= next_framing_error_flag;
            matched <= next_matched;
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
            tx_irq_o <= next_tx_irq;
            rx_pin_owned_o <= next_rx_own;
        end
    end

    // Oversample tick divider
    always_comb begin
        next_tick = (div == 16'h0000);
        next_div = next_tick ? DIV_LAST : div - 16'h0001;
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            div <= 16'h0000;
            tick <= 1'b0;
        end else begin
            div <= next_div;
            tick <= next_tick;
        end
    end

    // Transmitter; a pending break goes before queued data
    assign tx_pop = tx_on && tx_st == TX_IDLE && !ctrl.brk && f_valid;
    always_comb begin
        next_tx_st = tx_st;
        next_tx_sh = tx_sh;
        next_tx_cnt = tx_cnt;
        next_tx_sub = tx_sub;
        next_tx_brk = tx_brk;
        brk_done = 1'b0;
        unique case (tx_st)
            TX_IDLE: begin
                next_tx_sub = 4'h0;
                if (tx_on && ctrl.brk) begin
                    next_tx_st = TX_SHIFT;
                    next_tx_sh = BRK_FRAME;
                    next_tx_cnt = BRK_BITS;
                    next_tx_brk = 1'b1;
                end else if (tx_pop) begin
                    next_tx_st = TX_SHIFT;
                    next_tx_sh = {5'h01, f_data, 1'b0};
                    next_tx_cnt = FRM_BITS;
                    next_tx_brk = 1'b0;
                end
            end
            TX_SHIFT: begin
                if (tick && tx_sub == OVS_LAST) begin
                    next_tx_sub = 4'h0;
                    next_tx_sh = {1'b1, tx_sh[13:1]};
                    next_tx_cnt = tx_cnt - 4'h1;
                    if (tx_cnt == 4'h1) begin
                        next_tx_st = TX_IDLE;
                        brk_done = tx_brk;
                        next_tx_brk = 1'b0;
                    end
                end else if (tick) begin
                    next_tx_sub = tx_sub + 4'h1;
                end
            end
        endcase
        // Disable aborts the frame in flight
        if (!tx_on) begin
            next_tx_st = TX_IDLE;
            next_tx_brk = 1'b0;
        end
        // Infrared sends a short pulse for each zero bit
        if (ctrl.ir) begin
            next_pin = (next_tx_st == TX_SHIFT && !next_tx_sh[0]
                && next_tx_sub < IR_PULSE) ? !ctrl.pol : ctrl.pol;
        end else begin
            next_pin = (next_tx_st == TX_SHIFT ? next_tx_sh[0] : 1'b1)
                ^ ctrl.pol;
        end
        next_oe = tx_on;
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_st <= TX_IDLE;
            tx_sh <= 14'h0000;
            tx_cnt <= 4'h0;
            tx_sub <= 4'h0;
            tx_brk <= 1'b0;
            serial_out_pin_o <= 1'b1;
            serial_out_pin_oe_o <= 1'b0;
        end else begin
            tx_st <= next_tx_st;
            tx_sh <= next_tx_sh;
            tx_cnt <= next_tx_cnt;
            tx_sub <= next_tx_sub;
            tx_brk <= next_tx_brk;
            serial_out_pin_o <= next_pin;
            serial_out_pin_oe_o <= next_oe;
        end
    end

    // Receiver; a released pin reads as idle line
    assign rx_line = rx_own ? rx_s2 : 1'b1;
    assign rx_take = rx_done
        && (!ctrl.adm || matched || rx_sh == ctrl.addr);
    always_comb begin
        next_rx_st = rx_st;
        next_rx_sub = rx_sub;
        next_rx_cnt = rx_cnt;
        next_rx_sh = rx_sh;
        rx_done = 1'b0;
        rx_bad = 1'b0;
        if (tick) begin
            next_rx_sub = rx_sub + 4'h1;
            unique case (rx_st)
                R_IDLE: begin
                    next_rx_sub = 4'h0;
                    if (!rx_line) begin
                        next_rx_st = R_START;
                    end
                end
                R_START: begin
                    // Mid-bit recheck rejects glitches
                    if (rx_sub == HALF_LAST) begin
                        next_rx_sub = 4'h0;
                        next_rx_cnt = 3'h0;
                        next_rx_st = rx_line ? R_IDLE : R_DATA;
                    end
                end
                R_DATA: begin
                    if (rx_sub == OVS_LAST) begin
                        next_rx_sh = {rx_line, rx_sh[7:1]};
                        next_rx_cnt = rx_cnt + 3'h1;
                        if (rx_cnt == DATA_LAST) begin
                            next_rx_st = R_STOP;
                        end
                    end
                end
                R_STOP: begin
                    if (rx_sub == OVS_LAST) begin
                        rx_done = 1'b1;
                        rx_bad = !rx_line;
                        next_rx_st = R_IDLE;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_st <= R_IDLE;
            rx_sub <= 4'h0;
            rx_cnt <= 3'h0;
            rx_sh <= 8'h00;
        end else begin
            rx_s1 <= serial_in_pin_i;
            rx_s2 <= rx_s1;
            rx_st <= next_rx_st;
            rx_sub <= next_rx_sub;
            rx_cnt <= next_rx_cnt;
            rx_sh <= next_rx_sh;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_brk_last;
        tx_on && tx_st == TX_SHIFT && tx_brk && tx_cnt == 4'h1
            && tx_sub == OVS_LAST && tick;
    endsequence
    sequence s_sta_read;
        acc && !pready_o && !pwrite_i && paddr_i == OFS_STA;
    endsequence
    // The match flag drops one cycle after detect is switched off
    chk_adm_off_pass: assert property (!ctrl.adm |=> !matched)
        else $error("address match held while detect disabled");
    chk_addr_drop: assert property (
        rx_done && ctrl.adm && !matched && rx_sh != ctrl.addr && !rd_rxd
        |=> rx_valid == $past(rx_valid))
        else $error("non-address character accepted");
    chk_irq_empty: assert property ($past(ctrl.txsel) == TXI_EMPTY
        |-> tx_irq_o == $past(f_empty))
        else $error("empty interrupt wrong");
    chk_irq_done: assert property ($past(ctrl.txsel) == TXI_DONE
        |-> tx_irq_o == $past(f_empty && tx_st == TX_IDLE))
        else $error("all-sent interrupt wrong");
    // First cycle after reset still shows the reset level
    chk_irq_room: assert property (!$past(srst_i)
        && $past(ctrl.txsel) == TXI_ROOM |-> tx_irq_o == !$past(f_full))
        else $error("room interrupt wrong");
    chk_idle_level: assert property (tx_on && tx_st == TX_IDLE
        && !ctrl.brk && !f_valid |=> serial_out_pin_o
        == ($past(ctrl.ir) ? $past(ctrl.pol) : !$past(ctrl.pol)))
        else $error("idle level wrong");
    chk_rx_release: assert property (
        !rx_own && rx_st == R_IDLE |=> rx_st == R_IDLE && !rx_pin_owned_o)
        else $error("released receive pin still used");
    chk_brk_clear: assert property (s_brk_last and !wr_sta
        |=> !ctrl.brk && tx_st == TX_IDLE)
        else $error("break bit not cleared at frame end");
    chk_tx_abort: assert property (!tx_on
        |=> tx_st == TX_IDLE && f_empty && !serial_out_pin_oe_o)
        else $error("transmit disable did not abort");
    chk_full_flag: assert property (s_sta_read
        |=> prdata_o[9] == $past(f_full) && prdata_o[31:25] == 7'h00)
        else $error("status read wrong");
    chk_overrun: assert property (rx_take && rx_valid && !rd_rxd
        |=> ovr && rx_data == $past(rx_data))
        else $error("overrun not flagged");
endmodule

// file: tb/usc_peer.sv
/*
 Remote serial transceiver model: decodes frames on the block's
 transmit line and sends frames into its receive line.
 Assumes plain 8N1 framing and a bit time of BIT clocks.
*/
`timescale 1ns/100ps
module usc_peer #(
    parameter int BIT = 32
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o,
    output logic [7:0] rx_byte_o,
    output logic [15:0] max_low_o
);
    int low; // Current low run in clocks
    initial begin
        line_o = 1'b1;
        rx_byte_o = 8'h00;
        max_low_o = 16'h0;
        low = 0;
    end
    // Longest low run, so a break shows as one long span
    always @(posedge clk_i) begin
        if (line_i === 1'b1) begin
            low = 0;
        end else begin
            low = low + 1;
        end
        if (low > max_low_o) begin
            max_low_o = low[15:0];
        end
    end
    // Decoder: mid-bit sampling, LSB first
    initial forever begin
        @(negedge line_i);
        repeat (BIT / 2) @(posedge clk_i);
        if (line_i === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk_i);
                rx_byte_o[i] = line_i;
            end
            repeat (BIT) @(posedge clk_i);
        end
    end
    // Start bit, data LSB first, stop bit; line idles high
    task send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            line_o <= f[i];
            repeat (BIT - 1) @(posedge clk_i);
        end
        repeat (BIT) @(posedge clk_i);
    endtask
endmodule

// file: tb/uart_status_control_test.sv
/*
 Self-checking bench: APB register sequences against the serial
 port status/control block and a serial peer model.
 Assumes a 10 MHz clock; BAUD shortened so a bit is 32 clocks.
*/
`timescale 1ns/100ps
module uart_status_control_test;
    import usc_pkg::*;
    localparam int BIT = 32; // Clocks per bit at BAUD below
    logic clk_i, srst_i, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, rx_pin, tx_pin, tx_oe, rx_own, tx_irq;
    logic err; // Error answer of the last transfer
    logic tx_line; // Transmit line as the peer sees it
    // A released pin falls back to the port's pull-up level
    assign tx_line = tx_oe ? tx_pin : 1'b1;
    logic [7:0] peer_byte;
    logic [15:0] peer_low;
    int failures, checked;
    usc_top #(.BAUD(312500), .FIFO_DEPTH(8)) u_dut (
        .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .serial_in_pin_i(rx_pin),
        .serial_out_pin_o(tx_pin), .serial_out_pin_oe_o(tx_oe),
        .rx_pin_owned_o(rx_own), .tx_irq_o(tx_irq));
    usc_peer #(.BIT(BIT)) u_peer (.clk_i(clk_i), .line_i(tx_line),
        .line_o(rx_pin), .rx_byte_o(peer_byte), .max_low_o(peer_low));
    // 100 ns clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // One APB transfer; read data lands in q
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task summarize();
        if (failures == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Watchdog against a stalled handshake
    initial begin
        repeat (60000) @(posedge clk_i);
        failures++;
        summarize();
    end
    initial begin
        failures = 0;
        checked = 0;
        // Bus idle; address and data stay unknown until the first call
        psel <= 1'b0;
        penable <= 1'b0;
        srst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        apb(1'b0, OFS_STA, 32'h0);
        chk("sta_reset", q, 32'h0000_0110);
        chk("irq_room", tx_irq, 32'h1);
        apb(1'b1, OFS_STA, 32'hfe41_8000);
        apb(1'b0, OFS_STA, 32'h0);
        chk("sta_upper", q, 32'h0041_8110);
        chk("irq_empty", tx_irq, 32'h1);
        apb(1'b1, OFS_MODE, 32'h0000_8000);
        apb(1'b1, OFS_STA, 32'h0000_4400);
        repeat (3) @(posedge clk_i);
        chk("tx_own", tx_oe, 32'h1);
        apb(1'b1, OFS_TXD, 32'h5a);
        repeat (3) @(posedge clk_i);
        chk("irq_busy", tx_irq, 32'h0);
        repeat (12 * BIT) @(posedge clk_i);
        chk("irq_done", tx_irq, 32'h1);
        chk("peer_byte", peer_byte, 32'h5a);
        // Shifter takes one, then eight fill the buffer
        for (int i = 0; i < 9; i++) apb(1'b1, OFS_TXD, 32'hff);
        apb(1'b0, OFS_STA, 32'h0);
        chk("full_set", q[9], 32'h1);
        apb(1'b1, OFS_STA, 32'h0000_0400);
        repeat (3) @(posedge clk_i);
        chk("irq_full", tx_irq, 32'h0);
        apb(1'b1, OFS_STA, 32'h0000_8000);
        apb(1'b0, OFS_STA, 32'h0);
        chk("full_flush", q[9], 32'h0);
        chk("irq_flushed", tx_irq, 32'h1);
        chk("tx_free", tx_oe, 32'h0);
        repeat (12 * BIT) @(posedge clk_i);
        apb(1'b1, OFS_STA, 32'h0000_0c00);
        apb(1'b1, OFS_TXD, 32'hff);
        repeat (30 * BIT) @(posedge clk_i);
        apb(1'b0, OFS_STA, 32'h0);
        chk("brk_clear", q[11], 32'h0);
        chk("brk_span", peer_low, 13 * BIT);
        apb(1'b1, OFS_STA, 32'h0000_2400);
        repeat (3) @(posedge clk_i);
        chk("idle_low", tx_pin, 32'h0);
        apb(1'b1, OFS_MODE, 32'h0000_9000);
        repeat (3) @(posedge clk_i);
        chk("ir_idle_hi", tx_pin, 32'h1);
        apb(1'b1, OFS_STA, 32'h0000_0400);
        repeat (3) @(posedge clk_i);
        chk("ir_idle_lo", tx_pin, 32'h0);
        apb(1'b1, OFS_MODE, 32'h0000_8000);
        chk("rx_free", rx_own, 32'h0);
        apb(1'b1, OFS_STA, 32'h0000_1000);
        repeat (3) @(posedge clk_i);
        chk("rx_own", rx_own, 32'h1);
        u_peer.send(8'h3c);
        apb(1'b0, OFS_STA, 32'h0);
        chk("rx_avail", q[0], 32'h1);
        apb(1'b0, OFS_RXD, 32'h0);
        chk("rx_data", q[7:0], 32'h3c);
        // Second word with the first unread overruns
        u_peer.send(8'h11);
        u_peer.send(8'h22);
        apb(1'b0, OFS_STA, 32'h0);
        chk("ovr_set", q[1], 32'h1);
        apb(1'b1, OFS_STA, 32'h0000_1000);
        apb(1'b0, OFS_STA, 32'h0);
        chk("ovr_clear", q[1], 32'h0);
        apb(1'b0, OFS_RXD, 32'h0);
        chk("ovr_keep", q[7:0], 32'h11);
        apb(1'b1, OFS_STA, 32'h0141_1000);
        u_peer.send(8'h22);
        apb(1'b0, OFS_STA, 32'h0);
        chk("adr_drop", q[0], 32'h0);
        u_peer.send(8'h41);
        apb(1'b0, OFS_RXD, 32'h0);
        chk("adr_match", q[7:0], 32'h41);
        apb(1'b1, OFS_STA, 32'h0041_1000);
        u_peer.send(8'h22);
        apb(1'b0, OFS_RXD, 32'h0);
        chk("adr_off", q[7:0], 32'h22);
        chk("map_ok", err, 32'h0);
        // Unmapped word answers with an error and reads zero
        apb(1'b0, 8'h10, 32'h0);
        chk("unmap_err", err, 32'h1);
        chk("unmap_data", q, 32'h0);
        summarize();
    end
endmodule
